//--- rtl/tx_pulse_cfg.svh
// Constants for the transmit pulse template sequencer.
// Assumes inclusion by bare name from every file that needs them.
`ifndef TX_PULSE_CFG_SVH
`define TX_PULSE_CFG_SVH

// Register offsets on the plain register port.
`define PT_CONFIG_ADDR  8'h15
`define PT_INDEX_ADDR   8'h16
`define PT_DATA_ADDR    8'h17

// Field positions inside the configuration register.
`define PT_ENABLE_BIT   0
`define PT_ACTIVE_BIT   1

// Reset values.
`define PT_ENABLE_RST   1'b0
`define PT_INDEX_RST    3'h0
`define PT_WORD_RST     4'h0

// Sequence shape: entries 0..3 form the body, 4..7 the tail.
`define PT_BODY_LAST    3'h3
`define PT_TAIL_LAST    3'h7

// Reference clock cycles per high-speed sample clock period.
`define PT_SAMPLE_DIV   4'h2

`endif

//--- rtl/tx_pulse_pkg.sv
// Types shared by the transmit pulse template sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package tx_pulse_pkg;

    typedef logic [3:0] amp_word_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_ARMED = 4'h2,
        ST_BODY  = 4'h4,
        ST_TAIL  = 4'h8
    } seq_state_e;

    // Drive toward one line output amplifier.
    typedef struct packed {
        logic      ground;
        amp_word_t code;
    } line_drive_s;

endpackage : tx_pulse_pkg

//--- rtl/sample_tick_divider.sv
// Divider that makes the high-speed sample clock as a one-cycle enable.
// Assumes a single reference clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "tx_pulse_cfg.svh"

module sample_tick_divider
(
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst,
    // Sample clock falling-edge strobe.
    output logic      sample_tick
);

    logic [3:0] count_q;

    always_ff @(posedge ref_clk)
    begin
        if (rst || count_q == `PT_SAMPLE_DIV - 4'h1)
            count_q <= 4'h0;
        else
            count_q <= count_q + 4'h1;
    end

    assign sample_tick = (count_q == `PT_SAMPLE_DIV - 4'h1);

endmodule : sample_tick_divider
`default_nettype wire

//--- rtl/line_output_stage.sv
// One line output amplifier stage: either drives a code or grounds the line.
// Assumes the sequencer never asks both stages to drive at once.
`timescale 1ns/1ps
`default_nettype none
`include "tx_pulse_cfg.svh"

module line_output_stage
(
    // Clock and reset.
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    // Request from the sequencer.
    input  wire logic                    drive,
    input  wire tx_pulse_pkg::amp_word_t word,
    // Registered drive to the converter and amplifier.
    output tx_pulse_pkg::line_drive_s    line_out
);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            line_out.ground <= 1'b1;
            line_out.code   <= `PT_WORD_RST;
        end
        else
        begin
            // The code goes straight to the converter: 0 is no output, 15 full swing.
            line_out.ground <= ~drive;
            line_out.code   <= drive ? word : `PT_WORD_RST;
        end
    end

endmodule : line_output_stage
`default_nettype wire

//--- rtl/transmit_pulse_template_sequencer.sv
// Transmit pulse template sequencer: template table, register port, sequencing.
// Assumes line clock and pulse inputs synchronous to ref_clk, 20 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "tx_pulse_cfg.svh"

module transmit_pulse_template_sequencer
(
    // Clock and reset.
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Register port.
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // Transmit side.
    input  wire logic                 transmit_line_clock,
    input  wire logic                 pulse_pos,
    input  wire logic                 pulse_neg,
    // Line outputs toward the converter and amplifiers.
    output tx_pulse_pkg::line_drive_s positive_line_output,
    output tx_pulse_pkg::line_drive_s negative_line_output
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register file and template table.

    tx_pulse_pkg::amp_word_t table_q [0:7];
    logic [2:0]              index_q;
    logic                    template_enable_q;
    logic                    wr_cfg;
    logic                    wr_index;
    logic                    wr_data;
    logic                    seq_active;
    tx_pulse_pkg::seq_state_e state_q;
    logic [2:0]              step_q;

    assign wr_cfg   = reg_wr && reg_addr == `PT_CONFIG_ADDR;
    assign wr_index = reg_wr && reg_addr == `PT_INDEX_ADDR;
    assign wr_data  = reg_wr && reg_addr == `PT_DATA_ADDR;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            template_enable_q <= `PT_ENABLE_RST;
        else if (wr_cfg)
            template_enable_q <= reg_wdata[`PT_ENABLE_BIT];
    end

    // Only three bits of the index are kept; upper bits read back as zero.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            index_q <= `PT_INDEX_RST;
        else if (wr_index)
            index_q <= reg_wdata[2:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 8; i++)
                table_q[i] <= `PT_WORD_RST;
        end
        else if (wr_data)
            table_q[index_q] <= reg_wdata[3:0];
    end

    assign seq_active = (state_q != tx_pulse_pkg::ST_IDLE);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                `PT_CONFIG_ADDR: reg_rdata <= {6'h00, seq_active, template_enable_q};
                `PT_INDEX_ADDR:  reg_rdata <= {5'h00, index_q};
                `PT_DATA_ADDR:   reg_rdata <= {4'h0, table_q[index_q]};
                default:         reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing.

    logic lclk_q;
    logic lclk_fall;
    logic sample_tick;
    logic pol_neg_q;
    logic body_drive;
    logic tail_drive;
    tx_pulse_pkg::amp_word_t sel_word;

    sample_tick_divider u_divider
    (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .sample_tick (sample_tick)
    );

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            // Low at reset, so a line clock already low never reads as a falling edge.
            lclk_q <= 1'b0;
        else
            lclk_q <= transmit_line_clock;
    end

    assign lclk_fall = lclk_q && !transmit_line_clock;

    // A new falling edge restarts the sequence, or drops to idle without a single pulse request, so a late tail never delays a pulse.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_q   <= tx_pulse_pkg::ST_IDLE;
            step_q    <= 3'h0;
            pol_neg_q <= 1'b0;
        end
        else if (!template_enable_q)
        begin
            state_q <= tx_pulse_pkg::ST_IDLE;
            step_q  <= 3'h0;
        end
        else if (lclk_fall)
        begin
            if (pulse_pos ^ pulse_neg)
            begin
                state_q   <= tx_pulse_pkg::ST_ARMED;
                pol_neg_q <= pulse_neg;
            end
            else
                state_q <= tx_pulse_pkg::ST_IDLE;
            step_q <= 3'h0;
        end
        else if (sample_tick)
        begin
            case (state_q)
                tx_pulse_pkg::ST_IDLE:
                    state_q <= tx_pulse_pkg::ST_IDLE;
                tx_pulse_pkg::ST_ARMED:
                begin
                    state_q <= tx_pulse_pkg::ST_BODY;
                    step_q  <= 3'h0;
                end
                tx_pulse_pkg::ST_BODY:
                begin
                    if (step_q == `PT_BODY_LAST)
                        state_q <= tx_pulse_pkg::ST_TAIL;
                    step_q <= step_q + 3'h1;
                end
                tx_pulse_pkg::ST_TAIL:
                begin
                    if (step_q == `PT_TAIL_LAST)
                    begin
                        state_q <= tx_pulse_pkg::ST_IDLE;
                        step_q  <= 3'h0;
                    end
                    else
                        step_q <= step_q + 3'h1;
                end
                default:
                begin
                    state_q <= tx_pulse_pkg::ST_IDLE;
                    step_q  <= 3'h0;
                end
            endcase
        end
    end

    assign sel_word   = table_q[step_q];
    assign body_drive = (state_q == tx_pulse_pkg::ST_BODY);
    assign tail_drive = (state_q == tx_pulse_pkg::ST_TAIL);

    // Polarity chooses which amplifier carries body and which the tail.
    line_output_stage u_pos_stage
    (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .drive    (pol_neg_q ? tail_drive : body_drive),
        .word     (sel_word),
        .line_out (positive_line_output)
    );

    line_output_stage u_neg_stage
    (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .drive    (pol_neg_q ? body_drive : tail_drive),
        .word     (sel_word),
        .line_out (negative_line_output)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_armed_tick;
        state_q == tx_pulse_pkg::ST_ARMED && sample_tick && template_enable_q && !lclk_fall;
    endsequence

    sequence s_pos_body;
        state_q == tx_pulse_pkg::ST_BODY && !pol_neg_q;
    endsequence

    sequence s_pos_tail;
        state_q == tx_pulse_pkg::ST_TAIL && !pol_neg_q;
    endsequence

    sequence s_write_then_read;
        (reg_wr && reg_addr == `PT_DATA_ADDR) ##1 (reg_rd && reg_addr == `PT_DATA_ADDR);
    endsequence

    AST_SEQ_START: assert property (@(posedge ref_clk) disable iff (rst)
        s_armed_tick |=> state_q == tx_pulse_pkg::ST_BODY && step_q == 3'h0)
        else $error("sequence did not start at entry 0");

    AST_STEP_ORDER: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == tx_pulse_pkg::ST_BODY && sample_tick && template_enable_q && !lclk_fall)
        |=> step_q == 3'(($past(step_q) + 3'h1)))
        else $error("template entries not applied in ascending order");

    AST_BODY_POS: assert property (@(posedge ref_clk) disable iff (rst)
        s_pos_body |=> !positive_line_output.ground
            && positive_line_output.code == $past(sel_word))
        else $error("positive pulse body not on positive output");

    AST_TAIL_NEG: assert property (@(posedge ref_clk) disable iff (rst)
        s_pos_tail |=> !negative_line_output.ground
            && negative_line_output.code == $past(sel_word) && positive_line_output.ground)
        else $error("positive pulse tail not on negative output");

    AST_BODY_SWAP: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == tx_pulse_pkg::ST_BODY && pol_neg_q) |=> !negative_line_output.ground
            && negative_line_output.code == $past(sel_word) && positive_line_output.ground)
        else $error("negative pulse body not swapped to negative output");

    AST_GROUND_OPP: assert property (@(posedge ref_clk) disable iff (rst)
        positive_line_output.ground || negative_line_output.ground)
        else $error("both line outputs driven at once");

    AST_READBACK: assert property (@(posedge ref_clk) disable iff (rst)
        s_write_then_read |=> reg_rdata == {4'h0, $past(reg_wdata[3:0], 2)})
        else $error("data read did not return the stored word");

    AST_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == `PT_DATA_ADDR) |=> reg_rdata[7:4] == 4'h0)
        else $error("upper data bits not zero");

    AST_ENABLE_GATE: assert property (@(posedge ref_clk) disable iff (rst)
        !template_enable_q |=> state_q == tx_pulse_pkg::ST_IDLE
            ##1 (positive_line_output.ground && negative_line_output.ground))
        else $error("pulses generated while template disabled");

    AST_PULSE_LEN: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == tx_pulse_pkg::ST_TAIL && step_q == `PT_TAIL_LAST && sample_tick
            && template_enable_q && !lclk_fall) |=> state_q == tx_pulse_pkg::ST_IDLE)
        else $error("sequence did not end after eight entries");

    AST_TAIL_SWAP: assert property (@(posedge ref_clk) disable iff (rst)
        (state_q == tx_pulse_pkg::ST_TAIL && pol_neg_q) |=> !positive_line_output.ground
            && positive_line_output.code == $past(sel_word) && negative_line_output.ground)
        else $error("negative pulse tail not swapped to positive output");

    AST_SEQ_ARM: assert property (@(posedge ref_clk) disable iff (rst)
        (lclk_fall && template_enable_q && (pulse_pos ^ pulse_neg))
            |=> state_q == tx_pulse_pkg::ST_ARMED && step_q == 3'h0)
        else $error("line clock fall did not arm the sequence at entry 0");

    // A grounded amplifier must not carry a stale code into the converter.
    AST_GROUND_CODE: assert property (@(posedge ref_clk) disable iff (rst)
        (!positive_line_output.ground || positive_line_output.code == `PT_WORD_RST)
            && (!negative_line_output.ground || negative_line_output.code == `PT_WORD_RST))
        else $error("grounded line output still carries a code");

    AST_INDEX_READ: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == `PT_INDEX_ADDR) |=> reg_rdata[7:3] == 5'h00)
        else $error("index read shows more than three bits");

    AST_UNMAPPED_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr != `PT_CONFIG_ADDR && reg_addr != `PT_INDEX_ADDR
            && reg_addr != `PT_DATA_ADDR) |=> reg_rdata == 8'h00)
        else $error("unmapped register read was not zero");

endmodule : transmit_pulse_template_sequencer
`default_nettype wire

//--- verif/line_primary_model.sv
// Behavioural transformer primary: the differential level seen across the two line outputs.
// Assumes each output either grounds its line or carries a converter code.
`timescale 1ns/1ps
`default_nettype none

module line_primary_model
(
    // Line outputs of the sequencer.
    input  wire tx_pulse_pkg::line_drive_s pos_line,
    input  wire tx_pulse_pkg::line_drive_s neg_line,
    // Observed primary.
    output logic signed [5:0]              diff_level,
    output logic                           both_driven
);
    logic [4:0] pos_lvl;
    logic [4:0] neg_lvl;

    // A grounded amplifier adds nothing, whatever code it still carries.
    assign pos_lvl     = pos_line.ground ? 5'h00 : {1'b0, pos_line.code};
    assign neg_lvl     = neg_line.ground ? 5'h00 : {1'b0, neg_line.code};
    assign diff_level  = $signed({1'b0, pos_lvl}) - $signed({1'b0, neg_lvl});
    assign both_driven = !pos_line.ground && !neg_line.ground;

endmodule : line_primary_model
`default_nettype wire

//--- verif/test_transmit_pulse_template_sequencer.sv
// Testbench for the transmit pulse template sequencer.
// Assumes the register port and line side behave as in the hand-over contract.
`timescale 1ns/1ps
`default_nettype none
`include "tx_pulse_cfg.svh"

module test_transmit_pulse_template_sequencer;
    localparam int TIMEOUT_CYCLES = 4000;
    logic                      ref_clk;
    logic                      rst;
    logic [7:0]                reg_addr;
    logic [7:0]                reg_wdata;
    logic                      reg_wr;
    logic                      reg_rd;
    logic [7:0]                reg_rdata;
    logic                      line_clk;
    logic                      pulse_pos;
    logic                      pulse_neg;
    tx_pulse_pkg::line_drive_s pos_out;
    tx_pulse_pkg::line_drive_s neg_out;
    logic signed [5:0]         diff_level;
    logic                      both_driven;
    logic [3:0]                w [8] = '{4'hF, 4'hC, 4'h9, 4'h6, 4'h3, 4'h5, 4'hA, 4'h1};
    int                        fail_count = 0;
    int                        check_count = 0;
    int                        cycle_count = 0;

    transmit_pulse_template_sequencer i_transmit_pulse_template_sequencer
    (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .transmit_line_clock(line_clk), .pulse_pos(pulse_pos), .pulse_neg(pulse_neg),
        .positive_line_output(pos_out), .negative_line_output(neg_out)
    );

    line_primary_model i_line_primary_model
    (
        .pos_line(pos_out), .neg_line(neg_out),
        .diff_level(diff_level), .both_driven(both_driven)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == TIMEOUT_CYCLES)
        begin
            fail_count++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (fail_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Each strobe is dropped on the same edge that takes it, so calls never collide.
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        @(negedge ref_clk);
        check(reg_rdata, exp);
    endtask : reg_check

    // Index write, data write and data read on three edges in a row, with no gaps.
    task automatic reg_burst(input logic [2:0] idx, input logic [3:0] d);
        @(posedge ref_clk);
        reg_addr  <= `PT_INDEX_ADDR;
        reg_wdata <= {5'h00, idx};
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_addr  <= `PT_DATA_ADDR;
        reg_wdata <= {4'h0, d};
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge ref_clk);
        reg_rd    <= 1'b0;
        @(negedge ref_clk);
        check(reg_rdata, {4'h0, d});
    endtask : reg_burst

    // A sign of zero means no pulse may appear on the primary.
    task automatic run_pulse(input logic p, input logic n, input int sgn);
        int k;
        int e;
        bit seen;
        @(posedge ref_clk);
        line_clk  <= 1'b1;
        pulse_pos <= p;
        pulse_neg <= n;
        repeat (3) @(posedge ref_clk);
        line_clk  <= 1'b0;
        seen = 1'b0;
        for (k = 0; k < 10 && !seen; k++)
        begin
            @(negedge ref_clk);
            seen = (diff_level !== 6'sd0);
        end
        check({7'h00, seen}, {7'h00, sgn != 0});
        if (seen)
        begin
            for (k = 0; k < 16; k++)
            begin
                e = (k < 8) ? sgn * int'(w[k / 2]) : -sgn * int'(w[k / 2]);
                check(8'(diff_level), 8'(e));
                check({7'h00, both_driven}, 8'h00);
                @(negedge ref_clk);
            end
            check(8'(diff_level), 8'h00);
        end
    endtask : run_pulse

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst       <= 1'b1;
        reg_addr  <= 8'h00;
        reg_wdata <= 8'h00;
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        line_clk  <= 1'b0;
        pulse_pos <= 1'b0;
        pulse_neg <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        reg_check(`PT_INDEX_ADDR, 8'h00);
        reg_check(`PT_DATA_ADDR, 8'h00);
        reg_check(`PT_CONFIG_ADDR, 8'h00);
        reg_write(8'h3C, 8'hFF);
        reg_check(8'h3C, 8'h00);
        reg_write(`PT_CONFIG_ADDR, 8'h00);
        // Upper bits set on purpose: only three index bits and four word bits count.
        for (int k = 0; k < 8; k++)
        begin
            reg_write(`PT_INDEX_ADDR, 8'hF8 | 8'(k));
            reg_write(`PT_DATA_ADDR, {4'hA, w[k]});
        end
        for (int k = 0; k < 8; k++)
        begin
            reg_write(`PT_INDEX_ADDR, 8'(k));
            reg_check(`PT_INDEX_ADDR, 8'(k));
            reg_check(`PT_DATA_ADDR, {4'h0, w[k]});
        end
        run_pulse(1'b1, 1'b0, 0);
        reg_write(`PT_CONFIG_ADDR, 8'h03);
        reg_check(`PT_CONFIG_ADDR, 8'h01);
        run_pulse(1'b1, 1'b0, 1);
        run_pulse(1'b0, 1'b1, -1);
        run_pulse(1'b1, 1'b1, 0);
        reg_write(`PT_INDEX_ADDR, 8'h06);
        reg_check(`PT_DATA_ADDR, {4'h0, w[6]});
        reg_burst(3'h2, 4'h9);
        reg_burst(3'h5, 4'h0);
        finish_test();
    end

endmodule : test_transmit_pulse_template_sequencer
`default_nettype wire
